//--- rtl/status_pkg.sv
// Purpose: Shared constants and carriers for instrument status reporting
// Assumes: One clock, synchronous active-high reset
// Notes:   Codes, positions and carriers only, no logic
package status_pkg;
  localparam int EVT_W = 8;
  localparam int OPER_W = 16;
  localparam int RSP_W = 16;

  localparam int EVT_OPC = 0;
  localparam int EVT_QUERY = 2;
  localparam int EVT_DEVICE = 3;
  localparam int EVT_EXEC = 4;
  localparam int EVT_CMD = 5;
  localparam int EVT_USER = 6;
  localparam int EVT_PON = 7;
  localparam logic [7:0] EVT_USED_MASK = 8'hFD;

  localparam int SBYTE_SUM = 5;
  localparam int SBYTE_MSS = 6;

  localparam int OPER_ALIGN = 0;
  localparam int OPER_SWEEP = 3;
  localparam int OPER_MEAS = 4;
  localparam int OPER_TRIG = 5;
  localparam int OPER_HCOPY = 8;
  localparam int OPER_ZERO = 15;
  localparam logic [15:0] OPER_USED_MASK = 16'h0139;

  localparam logic [7:0] POLL_MASK_RST = 8'h00;
  localparam logic [7:0] EVT_MASK_RST = 8'h00;

  // Two's complement of -300, -200, -100
  localparam logic [15:0] ERR_CODE_DEVICE = 16'hFED4;
  localparam logic [15:0] ERR_CODE_EXEC = 16'hFF38;
  localparam logic [15:0] ERR_CODE_CMD = 16'hFF9C;

  typedef enum logic [3:0] {
    CMD_NONE          = 4'h0,
    CMD_POLL_SET      = 4'h1,
    CMD_POLL_QRY      = 4'h2,
    CMD_FLAG_QRY      = 4'h3,
    CMD_EMASK_SET     = 4'h4,
    CMD_EMASK_QRY     = 4'h5,
    CMD_EVT_QRY       = 4'h6,
    CMD_OPC           = 4'h7,
    CMD_OPER_COND_QRY = 4'h8,
    CMD_OPER_EVT_QRY  = 4'h9
  } cmd_e;

  typedef enum logic [1:0] {
    OPC_IDLE = 2'b01,
    OPC_WAIT = 2'b10
  } opc_state_e;

  typedef struct packed {
    logic       valid;
    cmd_e       code;
    logic [7:0] data;
  } cmd_s;

  typedef struct packed {
    logic              valid;
    logic [RSP_W-1:0] data;
  } rsp_s;

  typedef struct packed {
    logic self_alignment_active;
    logic sweep_active;
    logic measurement_active;
    logic trigger_wait;
    logic hardcopy_active;
    logic app_active;
  } act_s;

  typedef struct packed {
    logic query;
    logic device;
    logic execution;
    logic command;
    logic to_local;
  } err_s;
endpackage

//--- rtl/status_reporting.sv
// Purpose: Status byte summary, INDIVIDUAL_STATUS_FLAG flag, event and operation registers
// Assumes: Command decoder and activity sources run on CORE_CLK
// Notes:   Service request and questionable tree live elsewhere
`timescale 1ns/100ps
module status_reporting
  import status_pkg::*;
(
  input  wire logic        CORE_CLK,    // 25 MHz core clock
  input  wire logic        RST,         // Sync reset, high
  input  wire cmd_s        CMD,         // Decoded common command
  input  wire logic        CMDS_BUSY,   // Earlier commands executing
  input  wire logic        PPOLL_REQ,   // Parallel poll in progress
  input  wire logic [7:0]  SBYTE_IN,    // Other status byte sources
  input  wire act_s        ACT,         // Instrument activities
  input  wire err_s        ERR,         // Error and local pulses
  output rsp_s             RSP,         // Query reply
  output logic [7:0]       STATUS_BYTE, // Assembled status byte
  output logic             STATUS_FLAG, // Individual status flag
  output logic             PPOLL_RSP,   // Flag on parallel poll
  output logic             ERR_PUSH,    // Error queue write
  output logic [15:0]      ERR_CODE     // Error queue entry
);

  logic [7:0]        poll_mask_ff;
  logic [7:0]        evt_mask_ff;
  logic [EVT_W-1:0]  evt_bits;
  logic [EVT_W-1:0]  evt_set;
  logic [OPER_W-1:0] oper_cond_ff;
  logic [OPER_W-1:0] nxt_oper_cond;
  logic [OPER_W-1:0] oper_evt;
  logic [OPER_W-1:0] oper_set;
  logic              por_ff;
  opc_state_e        opc_ff;
  opc_state_e        nxt_opc;
  logic              opc_fire;
  logic              evt_sum;
  logic [7:0]        nxt_sbyte;
  rsp_s              rsp_ff;
  rsp_s              nxt_rsp;
  logic [7:0]        sbyte_ff;
  logic              flag_ff;
  logic              ppoll_ff;
  logic              err_push_ff;
  logic [15:0]       err_code_ff;
  logic              evt_rd;
  logic              oper_rd;

  assign evt_rd = CMD.valid && (CMD.code == CMD_EVT_QRY);
  assign oper_rd = CMD.valid && (CMD.code == CMD_OPER_EVT_QRY);

  // Poll and event enable masks
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      poll_mask_ff <= POLL_MASK_RST;
    end else if (CMD.valid && CMD.code == CMD_POLL_SET) begin
      poll_mask_ff <= CMD.data;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      evt_mask_ff <= EVT_MASK_RST;
    end else if (CMD.valid && CMD.code == CMD_EMASK_SET) begin
      evt_mask_ff <= CMD.data;
    end
  end

  // Power-on marker, raised by reset and consumed once
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      por_ff <= 1'b1;
    end else begin
      por_ff <= 1'b0;
    end
  end

  // Operation-complete waits for the command pipe to drain
  always_comb begin
    nxt_opc = opc_ff;
    opc_fire = 1'b0;
    unique case (opc_ff)
      OPC_IDLE: begin
        if (CMD.valid && CMD.code == CMD_OPC) begin
          nxt_opc = OPC_WAIT;
        end
      end
      OPC_WAIT: begin
        if (!CMDS_BUSY) begin
          opc_fire = 1'b1;
          nxt_opc = OPC_IDLE;
        end
      end
      default: begin
        nxt_opc = OPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      opc_ff <= OPC_IDLE;
    end else begin
      opc_ff <= nxt_opc;
    end
  end

  // Event status sources
  always_comb begin
    evt_set = 8'h00;
    evt_set[EVT_OPC] = opc_fire;
    evt_set[EVT_QUERY] = ERR.query;
    evt_set[EVT_DEVICE] = ERR.device;
    evt_set[EVT_EXEC] = ERR.execution;
    evt_set[EVT_CMD] = ERR.command;
    evt_set[EVT_USER] = ERR.to_local;
    evt_set[EVT_PON] = por_ff;
    evt_set = evt_set & EVT_USED_MASK;
  end

  // Read clears, but a same-cycle event still lands
  sticky_bits #(
    .W (EVT_W)
  ) u_evt (
    .clk     (CORE_CLK),
    .rst     (RST),
    .set_vec (evt_set),
    .clr     (evt_rd),
    .bits    (evt_bits)
  );

  // Error queue entry, worst class wins on collision
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      err_push_ff <= 1'b0;
      err_code_ff <= 16'h0000;
    end else begin
      err_push_ff <= ERR.command | ERR.execution | ERR.device;
      if (ERR.command) begin
        err_code_ff <= ERR_CODE_CMD;
      end else if (ERR.execution) begin
        err_code_ff <= ERR_CODE_EXEC;
      end else if (ERR.device) begin
        err_code_ff <= ERR_CODE_DEVICE;
      end
    end
  end

  // Operation condition view
  always_comb begin
    nxt_oper_cond = 16'h0000;
    nxt_oper_cond[OPER_ALIGN] = ACT.self_alignment_active;
    nxt_oper_cond[OPER_SWEEP] = !ACT.app_active &&
        (ACT.sweep_active || ACT.measurement_active);
    nxt_oper_cond[OPER_MEAS] = nxt_oper_cond[OPER_SWEEP];
    nxt_oper_cond[OPER_TRIG] = ACT.trigger_wait;
    nxt_oper_cond[OPER_HCOPY] = ACT.hardcopy_active;
    nxt_oper_cond[OPER_ZERO] = 1'b0;
    nxt_oper_cond = nxt_oper_cond & OPER_USED_MASK;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      oper_cond_ff <= 16'h0000;
    end else begin
      oper_cond_ff <= nxt_oper_cond;
    end
  end

  // Event view remembers activities begun since last read
  assign oper_set = nxt_oper_cond & ~oper_cond_ff;

  sticky_bits #(
    .W (OPER_W)
  ) u_oper_evt (
    .clk     (CORE_CLK),
    .rst     (RST),
    .set_vec (oper_set),
    .clr     (oper_rd),
    .bits    (oper_evt)
  );

  // Summary level is the OR of latched event bits under the enable mask
  assign evt_sum = |(evt_bits & evt_mask_ff);
  always_comb begin
    nxt_sbyte = SBYTE_IN;
    nxt_sbyte[SBYTE_SUM] = evt_sum;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sbyte_ff <= 8'h00;
      flag_ff <= 1'b0;
    end else begin
      sbyte_ff <= nxt_sbyte;
      flag_ff <= |(nxt_sbyte & poll_mask_ff);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ppoll_ff <= 1'b0;
    end else begin
      ppoll_ff <= PPOLL_REQ & flag_ff;
    end
  end

  // Query replies, one cycle after the command
  always_comb begin
    nxt_rsp = '0;
    if (CMD.valid) begin
      unique case (CMD.code)
        CMD_POLL_QRY: begin
          nxt_rsp.valid = 1'b1;
          nxt_rsp.data = {8'h00, poll_mask_ff};
        end
        CMD_FLAG_QRY: begin
          nxt_rsp.valid = 1'b1;
          nxt_rsp.data = {15'h0000, flag_ff};
        end
        CMD_EMASK_QRY: begin
          nxt_rsp.valid = 1'b1;
          nxt_rsp.data = {8'h00, evt_mask_ff};
        end
        CMD_EVT_QRY: begin
          nxt_rsp.valid = 1'b1;
          nxt_rsp.data = {8'h00, evt_bits};
        end
        CMD_OPER_COND_QRY: begin
          nxt_rsp.valid = 1'b1;
          nxt_rsp.data = oper_cond_ff;
        end
        CMD_OPER_EVT_QRY: begin
          nxt_rsp.valid = 1'b1;
          nxt_rsp.data = oper_evt;
        end
        CMD_NONE, CMD_POLL_SET, CMD_EMASK_SET, CMD_OPC: begin
          nxt_rsp = '0;
        end
        default: begin
          nxt_rsp = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  assign RSP = rsp_ff;
  assign STATUS_BYTE = sbyte_ff;
  assign STATUS_FLAG = flag_ff;
  assign PPOLL_RSP = ppoll_ff;
  assign ERR_PUSH = err_push_ff;
  assign ERR_CODE = err_code_ff;

  property p_flag_mask;
    @(posedge CORE_CLK) disable iff (RST)
    !$past(RST) |-> (flag_ff == |(sbyte_ff & $past(poll_mask_ff)));
  endproperty
  a_flag_mask: assert property (p_flag_mask)
    else $error("Status flag does not match masked status byte");

  property p_flag_query;
    @(posedge CORE_CLK) disable iff (RST)
    (CMD.valid && CMD.code == CMD_FLAG_QRY)
      |=> (RSP.valid && RSP.data == {15'h0000, $past(flag_ff)});
  endproperty
  a_flag_query: assert property (p_flag_query)
    else $error("Status flag query reply wrong");

  property p_poll_rsp;
    @(posedge CORE_CLK) disable iff (RST)
    PPOLL_REQ |=> (PPOLL_RSP == $past(flag_ff));
  endproperty
  a_poll_rsp: assert property (p_poll_rsp)
    else $error("Parallel poll answer wrong");

  property p_mask_roundtrip;
    @(posedge CORE_CLK) disable iff (RST)
    (CMD.valid && CMD.code == CMD_POLL_SET) ##1
      (CMD.valid && CMD.code == CMD_POLL_QRY)
      |=> (RSP.valid && RSP.data[7:0] == $past(CMD.data, 2));
  endproperty
  a_mask_roundtrip: assert property (p_mask_roundtrip)
    else $error("Poll mask not returned unchanged");

  property p_sum_bit;
    @(posedge CORE_CLK) disable iff (RST)
    !$past(RST) |-> (STATUS_BYTE[SBYTE_SUM] == |($past(evt_bits) & $past(evt_mask_ff)));
  endproperty
  a_sum_bit: assert property (p_sum_bit)
    else $error("Event summary bit wrong");

  property p_align_bit;
    @(posedge CORE_CLK) disable iff (RST)
    !$past(RST) |-> (oper_cond_ff[OPER_ALIGN] == $past(ACT.self_alignment_active));
  endproperty
  a_align_bit: assert property (p_align_bit)
    else $error("Alignment bit does not follow activity");

  property p_opc_set;
    @(posedge CORE_CLK) disable iff (RST)
    (opc_ff == OPC_WAIT && !CMDS_BUSY) |=> evt_bits[EVT_OPC];
  endproperty
  a_opc_set: assert property (p_opc_set)
    else $error("Operation complete not flagged");

  property p_cmd_err;
    @(posedge CORE_CLK) disable iff (RST)
    ERR.command |=> (evt_bits[EVT_CMD] && ERR_PUSH && ERR_CODE == ERR_CODE_CMD);
  endproperty
  a_cmd_err: assert property (p_cmd_err)
    else $error("Command error not recorded");

  property p_power_on;
    @(posedge CORE_CLK) disable iff (RST)
    $fell(RST) |-> ##1 evt_bits[EVT_PON];
  endproperty
  a_power_on: assert property (p_power_on)
    else $error("Power-on bit not set");

  property p_app_bits;
    @(posedge CORE_CLK) disable iff (RST)
    ACT.app_active |=> (oper_cond_ff[OPER_MEAS:OPER_SWEEP] == 2'b00);
  endproperty
  a_app_bits: assert property (p_app_bits)
    else $error("Sweep bits set in application");

  property p_unused_zero;
    @(posedge CORE_CLK) disable iff (RST)
    ((oper_cond_ff | oper_evt) & ~OPER_USED_MASK) == 16'h0000
      && evt_bits[1] == 1'b0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("Unused status bit set");

  property p_esr_clear;
    @(posedge CORE_CLK) disable iff (RST)
    (evt_rd && evt_set == 8'h00) |=> (evt_bits == 8'h00);
  endproperty
  a_esr_clear: assert property (p_esr_clear)
    else $error("Event status not cleared by read");

endmodule

//--- rtl/sticky_bits.sv
// Purpose: Sticky event bits with read-clear
// Assumes: Set vector and clear are on the same clock
// Notes:   A set in the clear cycle survives the clear
`timescale 1ns/100ps
module sticky_bits #(
  parameter int W = 8
) (
  input  wire logic         clk,     // Core clock
  input  wire logic         rst,     // Sync reset, high
  input  wire logic [W-1:0] set_vec, // Bits to set
  input  wire logic         clr,     // Clear all bits
  output logic      [W-1:0] bits     // Sticky state
);
  always_ff @(posedge clk) begin
    if (rst) begin
      bits <= '0;
    end else if (clr) begin
      bits <= set_vec;
    end else begin
      bits <= bits | set_vec;
    end
  end
endmodule

//--- tb/remote_ctrl.sv
// Purpose: Remote controller model issuing commands and parallel polls
// Assumes: Tasks are entered just after a rising clock edge
// Notes:   Idle command data shows inverted last value, never a stale copy
`timescale 1ns/100ps
module remote_ctrl
  import status_pkg::*;
(
  input  wire logic clk,       // Core clock
  input  wire rsp_s rsp,       // Query reply
  input  wire logic ppoll_rsp, // Poll answer
  output cmd_s      cmd,       // Command to device
  output logic      ppoll_req  // Poll request
);
  initial begin
    cmd       = '0;
    ppoll_req = 1'b0;
  end

  // Held until the taking edge; left up so a query may follow at once
  task automatic send(input cmd_e c, input logic [7:0] d);
    cmd <= '{valid: 1'b1, code: c, data: d};
    @(posedge clk);
  endtask

  task automatic set(input cmd_e c, input logic [7:0] d);
    send(c, d);
    cmd <= '{valid: 1'b0, code: CMD_NONE, data: ~d};
    @(posedge clk);
  endtask

  task automatic query(input cmd_e c, output rsp_s r);
    send(c, 8'h00);
    cmd <= '{valid: 1'b0, code: CMD_NONE, data: 8'hFF};
    @(posedge clk);
    r = rsp;
  endtask

  task automatic poll(output logic f);
    ppoll_req <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    f = ppoll_rsp;
    ppoll_req <= 1'b0;
    @(posedge clk);
  endtask
endmodule

//--- tb/status_reporting_tb.sv
// Purpose: Self-checking bench for status byte, flag, event and operation registers
// Assumes: remote_ctrl drives the command and poll side
// Notes:   Expectations come from bit positions and package codes
`timescale 1ns/100ps
module status_reporting_tb;
  import status_pkg::*;
  logic        core_clk    = 1'b0;
  logic        rst         = 1'b1;
  logic        busy        = 1'b0;
  logic [7:0]  sbyte_in    = 8'h00;
  act_s        act         = '0;
  err_s        err         = '0;
  cmd_s        cmd;
  logic        ppoll_req;
  rsp_s        rsp;
  logic [7:0]  status_byte;
  logic        status_flag;
  logic        ppoll_rsp;
  logic        err_push;
  logic [15:0] err_code;
  int          miscompares = 0;
  int          checked     = 0;

  always #20 core_clk = ~core_clk;

  status_reporting status_reporting_inst (
    .CORE_CLK(core_clk), .RST(rst), .CMD(cmd), .CMDS_BUSY(busy),
    .PPOLL_REQ(ppoll_req), .SBYTE_IN(sbyte_in), .ACT(act), .ERR(err),
    .RSP(rsp), .STATUS_BYTE(status_byte), .STATUS_FLAG(status_flag),
    .PPOLL_RSP(ppoll_rsp), .ERR_PUSH(err_push), .ERR_CODE(err_code)
  );

  remote_ctrl remote_ctrl_inst (
    .clk(core_clk), .rsp(rsp), .ppoll_rsp(ppoll_rsp), .cmd(cmd), .ppoll_req(ppoll_req)
  );

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic q(input cmd_e c, input logic [15:0] exp);
    rsp_s r;
    remote_ctrl_inst.query(c, r);
    chk_bit(r.valid, 1'b1);
    chk_word(r.data, exp);
  endtask

  task automatic pulse(input err_s v);
    err <= v;
    @(posedge core_clk);
    err <= '0;
    @(posedge core_clk);
  endtask

  task automatic t_reset;
    tick(2);
    q(CMD_EVT_QRY, 16'h0080);
    q(CMD_EVT_QRY, 16'h0000);
    q(CMD_POLL_QRY, 16'h0000);
    q(CMD_EMASK_QRY, 16'h0000);
    q(CMD_OPER_COND_QRY, 16'h0000);
    $display("test reset done");
  endtask

  // Set then query on the very next cycle
  task automatic t_masks;
    remote_ctrl_inst.send(CMD_POLL_SET, 8'h5A);
    q(CMD_POLL_QRY, 16'h005A);
    remote_ctrl_inst.send(CMD_EMASK_SET, 8'hA5);
    q(CMD_EMASK_QRY, 16'h00A5);
    $display("test masks done");
  endtask

  task automatic t_flag;
    logic [7:0] pm  [5] = '{8'h40, 8'h40, 8'h00, 8'h81, 8'h20};
    logic [7:0] sb  [5] = '{8'h40, 8'hBF, 8'hDF, 8'h01, 8'h20};
    logic       exp [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic       f;
    for (int i = 0; i < 5; i++) begin
      remote_ctrl_inst.set(CMD_POLL_SET, pm[i]);
      sbyte_in <= sb[i];
      tick(2);
      chk_bit(status_flag, exp[i]);
      chk_word({8'h00, status_byte}, {8'h00, sb[i] & 8'hDF});
      q(CMD_FLAG_QRY, {15'h0000, exp[i]});
      remote_ctrl_inst.poll(f);
      chk_bit(f, exp[i]);
    end
    sbyte_in <= 8'h00;
    $display("test flag done");
  endtask

  task automatic t_err;
    logic [15:0] code [5] = '{16'h0000, ERR_CODE_DEVICE, ERR_CODE_EXEC, ERR_CODE_CMD, 16'h0000};
    int          pos  [5] = '{EVT_QUERY, EVT_DEVICE, EVT_EXEC, EVT_CMD, EVT_USER};
    remote_ctrl_inst.set(CMD_EMASK_SET, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      pulse(err_s'(5'b10000 >> i));
      chk_bit(err_push, i inside {[1:3]});
      if (i inside {[1:3]}) chk_word(err_code, code[i]);
      tick(1);
      chk_bit(status_byte[SBYTE_SUM], 1'b1);
      q(CMD_EVT_QRY, 16'h0001 << pos[i]);
      tick(1);
      chk_bit(status_byte[SBYTE_SUM], 1'b0);
    end
    // Disabled bit must not reach the summary
    remote_ctrl_inst.set(CMD_EMASK_SET, 8'hFB);
    pulse(err_s'(5'b10000));
    tick(1);
    chk_bit(status_byte[SBYTE_SUM], 1'b0);
    pulse(err_s'(5'b01110));
    chk_word(err_code, ERR_CODE_CMD);
    q(CMD_EVT_QRY, 16'h003C);
    $display("test errors done");
  endtask

  task automatic t_opc;
    int n = 0;
    remote_ctrl_inst.set(CMD_EMASK_SET, 8'h01);
    busy <= 1'b1;
    remote_ctrl_inst.set(CMD_OPC, 8'h00);
    tick(3);
    chk_bit(status_byte[SBYTE_SUM], 1'b0);
    busy <= 1'b0;
    while (status_byte[SBYTE_SUM] !== 1'b1 && n < 6) begin
      tick(1);
      n++;
    end
    if (n == 6) begin
      miscompares++;
      $display("MISMATCH t=%0t completion flag never came", $time);
      summarize();
    end
    chk_word(16'(n), 16'h0003);
    q(CMD_EVT_QRY, 16'h0001);
    $display("test completion done");
  endtask

  task automatic t_oper;
    act_s        a [7] = '{6'h20, 6'h10, 6'h08, 6'h19, 6'h04, 6'h02, 6'h3E};
    logic [15:0] e [7] = '{16'h0001, 16'h0018, 16'h0018, 16'h0000,
                           16'h0020, 16'h0100, 16'h0139};
    for (int i = 0; i < 7; i++) begin
      act <= a[i];
      tick(1);
      q(CMD_OPER_COND_QRY, e[i]);
    end
    act <= '0;
    tick(1);
    q(CMD_OPER_COND_QRY, 16'h0000);
    q(CMD_OPER_EVT_QRY, 16'h0139);
    q(CMD_OPER_EVT_QRY, 16'h0000);
    $display("test operation done");
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_masks();
    t_flag();
    t_err();
    t_opc();
    t_oper();
    summarize();
  end
endmodule
